// ===== rtl/adcr_pkg.sv
// Constants shared by the converter result path: register map, fields, reset values.
// Assumes a 32-bit AHB-Lite register bus and a 16-word result FIFO.
package adcr_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_RESTART = 8'h2C;
    localparam logic [7:0] OFF_POLARITY = 8'h3C;
    localparam logic [7:0] OFF_FIFOCTL = 8'h40;
    localparam logic [7:0] OFF_RESULT = 8'h44;
    localparam logic [7:0] OFF_EVENT = 8'h60;

    // ==========================================================
    // Reset values
    localparam logic [31:0] RST_POLARITY = 32'hFFFFDFFF;
    localparam logic [31:0] RST_RESULT = 32'h811FFFFF;
    localparam logic [15:0] RST_RESTART = 16'h0000;

    // ==========================================================
    // Field positions
    localparam int CNT_MSB = 15;
    localparam int THR_LSB = 8;
    localparam int THR_MSB = 15;
    localparam int FMT_LSB = 2;
    localparam int FMT_MSB = 3;
    localparam int FLUSH_BIT = 1;
    localparam int DMAEN_BIT = 0;
    localparam int RES_CLIP_BIT = 31;
    localparam int RES_INV_BIT = 24;
    localparam int RES_CHAN_LSB = 16;
    localparam int RES_CHAN_MSB = 20;
    localparam int RES_DATA_MSB = 15;
    localparam int PROC_W = 12;
    localparam int RAW_W = 18;
    localparam int CHAN_W = 5;
    localparam int EVT_LVL_BIT = 0;
    localparam int EVT_CNT_LSB = 8;
    localparam int EVT_EMPTY_BIT = 16;
    localparam int EVT_FULL_BIT = 17;

    // ==========================================================
    // Sizes
    localparam int NUM_CHAN = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = 32;
    localparam int LVL_W = 5;

    // ==========================================================
    // FIFO word formats
    typedef enum logic [1:0] {
        FMT_STATUS = 2'h0,
        FMT_DATA = 2'h1,
        FMT_RAW = 2'h2,
        FMT_RSVD = 2'h3
    } adcr_fmt_t;

endpackage

// ===== rtl/adcr_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock; flush wins over a push or pop in the same cycle.
`timescale 1ns/1ns
module adcr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    // Level
    output logic [$clog2(DEPTH+1)-1:0] count_o
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic not_full;

    wire push = in_valid_i & not_full & ~flush_i;
    wire pop = out_ready_i & (count != '0) & ~flush_i;
    wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);

    assign in_ready_o = not_full;
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign count_o = count;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            not_full <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + PW'(1);
            end
            count <= next_count;
            not_full <= (next_count != FULL_CNT);
        end
    end

endmodule // adcr_fifo

// ===== rtl/adcr_top.sv
// Result path of the converter: restart delay, channel input mode, result FIFO and data word.
// Assumes an AHB-Lite master, a converter core on clk_i and a sample clock arriving on a pin.
`timescale 1ns/1ns
module adcr_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Converter core sequencing
    input wire logic sample_clk_i,
    input wire logic continuous_i,
    input wire logic seq_done_i,
    output logic seq_start_o,
    output logic [adcr_pkg::NUM_CHAN-1:0] chan_single_o,
    // Converter core results
    input wire logic res_valid_i,
    output logic res_ready_o,
    input wire logic [adcr_pkg::CHAN_W-1:0] res_chan_i,
    input wire logic [adcr_pkg::PROC_W-1:0] res_proc_i,
    input wire logic [adcr_pkg::RAW_W-1:0] res_raw_i,
    input wire logic res_clip_i,
    input wire logic res_invalid_i,
    // DMA and level event
    output logic dma_req_o,
    output logic level_event_o
);

    typedef enum logic {
        RS_IDLE,
        RS_DELAY
    } adcr_rs_t;

    localparam int LW = adcr_pkg::LVL_W;

    // ==========================================================
    // Registers
    logic [adcr_pkg::CNT_MSB:0] restart_cnt;
    logic [31:0] polarity;
    logic [7:0] thresh;
    logic [1:0] fmt;
    logic dma_en;
    logic level_flag;

    // ==========================================================
    // Bus data phase state
    logic pend;
    logic pend_write;
    logic [7:0] pend_addr;

    wire take = hsel_i & htrans_i[1] & hready_i;
    wire wr_go = pend & pend_write;
    wire rd_go = pend & ~pend_write;
    wire wr_restart = wr_go & (pend_addr == adcr_pkg::OFF_RESTART);
    wire wr_polarity = wr_go & (pend_addr == adcr_pkg::OFF_POLARITY);
    wire wr_fifoctl = wr_go & (pend_addr == adcr_pkg::OFF_FIFOCTL);
    wire wr_event = wr_go & (pend_addr == adcr_pkg::OFF_EVENT);
    wire rd_result = rd_go & (pend_addr == adcr_pkg::OFF_RESULT);
    wire flush = wr_fifoctl & hwdata_i[adcr_pkg::FLUSH_BIT];

    // ==========================================================
    // FIFO
    logic fifo_out_valid;
    logic [adcr_pkg::FIFO_W-1:0] fifo_out_data;
    logic [LW-1:0] fifo_count;
    logic [adcr_pkg::FIFO_W-1:0] packed_word;

    wire pop = rd_result & fifo_out_valid;

    // Format is applied on entry so a later change leaves queued words alone
    wire [15:0] proc_field = {{(16 - adcr_pkg::PROC_W){1'b0}}, res_proc_i};
    wire [31:0] status_word = {res_clip_i, 6'h00, res_invalid_i, 3'h0, res_chan_i, proc_field};
    wire [31:0] data_word = {16'h0000, proc_field};
    wire [31:0] raw_word = {{(32 - adcr_pkg::RAW_W){1'b0}}, res_raw_i};

    always_comb begin
        unique case (adcr_pkg::adcr_fmt_t'(fmt))
            adcr_pkg::FMT_STATUS: packed_word = status_word;
            adcr_pkg::FMT_DATA: packed_word = data_word;
            adcr_pkg::FMT_RAW: packed_word = raw_word;
            adcr_pkg::FMT_RSVD: packed_word = status_word;
        endcase
    end

    adcr_fifo #(
        .WIDTH(adcr_pkg::FIFO_W),
        .DEPTH(adcr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .flush_i(flush),
        .in_valid_i(res_valid_i),
        .in_ready_o(res_ready_o),
        .in_data_i(packed_word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_out_data),
        .count_o(fifo_count)
    );

    // ==========================================================
    // Read mux
    wire above = ({3'h0, fifo_count} > thresh);
    wire fifo_full = (fifo_count == LW'(adcr_pkg::FIFO_DEPTH));
    wire [31:0] fifoctl_rd = {16'h0000, thresh, 4'h0, fmt, 1'b0, dma_en};
    wire [31:0] event_rd = {14'h0000, fifo_full, ~fifo_out_valid, 3'h0, fifo_count,
                            7'h00, level_flag};
    // Empty FIFO returns the reset word, which carries the invalid flag
    wire [31:0] result_rd = fifo_out_valid ? fifo_out_data : adcr_pkg::RST_RESULT;
    wire [31:0] next_rdata =
        (pend_addr == adcr_pkg::OFF_RESTART) ? {16'h0000, restart_cnt} :
        (pend_addr == adcr_pkg::OFF_POLARITY) ? polarity :
        (pend_addr == adcr_pkg::OFF_FIFOCTL) ? fifoctl_rd :
        (pend_addr == adcr_pkg::OFF_RESULT) ? result_rd :
        (pend_addr == adcr_pkg::OFF_EVENT) ? event_rd : 32'h00000000;

    // ==========================================================
    // AHB-Lite slave: one wait state on every transfer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pend <= 1'b0;
            pend_write <= 1'b0;
            pend_addr <= 8'h00;
            hreadyout_o <= 1'b1;
            hrdata_o <= 32'h00000000;
            hresp_o <= 1'b0;
        end else if (pend) begin
            pend <= 1'b0;
            hreadyout_o <= 1'b1;
            hrdata_o <= pend_write ? 32'h00000000 : next_rdata;
        end else if (take) begin
            pend <= 1'b1;
            pend_write <= hwrite_i;
            pend_addr <= haddr_i[7:0];
            hreadyout_o <= 1'b0;
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            restart_cnt <= adcr_pkg::RST_RESTART;
            polarity <= adcr_pkg::RST_POLARITY;
            thresh <= 8'h00;
            fmt <= 2'h0;
            dma_en <= 1'b0;
        end else begin
            if (wr_restart) begin
                restart_cnt <= hwdata_i[adcr_pkg::CNT_MSB:0];
            end
            if (wr_polarity) begin
                polarity <= hwdata_i;
            end
            if (wr_fifoctl) begin
                thresh <= hwdata_i[adcr_pkg::THR_MSB:adcr_pkg::THR_LSB];
                fmt <= hwdata_i[adcr_pkg::FMT_MSB:adcr_pkg::FMT_LSB];
                dma_en <= hwdata_i[adcr_pkg::DMAEN_BIT];
            end
        end
    end

    // ==========================================================
    // Watermark, DMA request and level event
    logic above_q;
    wire clr_level = wr_event & hwdata_i[adcr_pkg::EVT_LVL_BIT];
    wire set_level = above & ~above_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            above_q <= 1'b0;
            level_flag <= 1'b0;
            dma_req_o <= 1'b0;
            level_event_o <= 1'b0;
            chan_single_o <= '0;
        end else begin
            above_q <= above;
            // Set wins so a crossing in the clearing cycle is kept
            level_flag <= set_level | (level_flag & ~clr_level);
            dma_req_o <= above & dma_en;
            level_event_o <= set_level | (level_flag & ~clr_level);
            chan_single_o <= polarity[adcr_pkg::NUM_CHAN-1:0];
        end
    end

    // ==========================================================
    // Sample clock synchroniser and restart delay
    logic smp_s1;
    logic smp_s2;
    logic smp_s3;
    logic [adcr_pkg::CNT_MSB:0] delay_cnt;
    adcr_rs_t rs_state;

    wire smp_edge = smp_s2 & ~smp_s3;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            smp_s1 <= 1'b0;
            smp_s2 <= 1'b0;
            smp_s3 <= 1'b0;
        end else begin
            smp_s1 <= sample_clk_i;
            smp_s2 <= smp_s1;
            smp_s3 <= smp_s2;
        end
    end

    // The count starts at the first sample edge after sequence end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rs_state <= RS_IDLE;
            delay_cnt <= '0;
            seq_start_o <= 1'b0;
        end else begin
            seq_start_o <= 1'b0;
            unique case (rs_state)
                RS_IDLE: begin
                    if (seq_done_i && continuous_i) begin
                        rs_state <= RS_DELAY;
                        delay_cnt <= restart_cnt;
                    end
                end
                RS_DELAY: begin
                    if (delay_cnt == '0) begin
                        seq_start_o <= 1'b1;
                        rs_state <= RS_IDLE;
                    end else if (smp_edge) begin
                        delay_cnt <= delay_cnt - 16'h0001;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    a_restart_after_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        seq_start_o |-> $past(rs_state) == RS_DELAY && $past(delay_cnt) == '0)
        else $error("restart issued before delay ran out");

    a_delay_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rs_state == RS_DELAY && delay_cnt != '0 && !smp_edge) |=> $stable(delay_cnt))
        else $error("restart delay moved without a sample edge");

    a_polarity_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> chan_single_o == $past(polarity[adcr_pkg::NUM_CHAN-1:0]))
        else $error("channel mode output does not follow format register");

    a_dma_threshold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (dma_en && {3'h0, fifo_count} > thresh) |=> dma_req_o)
        else $error("dma request missing above watermark");

    a_dma_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !dma_en |=> !dma_req_o)
        else $error("dma request while dma disabled");

    a_level_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        set_level |=> level_flag && level_event_o)
        else $error("level event not set on watermark crossing");

    a_raw_format: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fmt == adcr_pkg::FMT_RAW |-> packed_word[31:adcr_pkg::RAW_W] == '0
        && packed_word[adcr_pkg::RAW_W-1:0] == res_raw_i)
        else $error("raw format word malformed");

    a_flush_empties: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        flush |=> fifo_count == '0 ##1 (hrdata_o[adcr_pkg::FLUSH_BIT] == 1'b0))
        else $error("flush left words in fifo");

    a_empty_invalid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rd_result && !fifo_out_valid) |=> hrdata_o == adcr_pkg::RST_RESULT
        && hrdata_o[adcr_pkg::RES_INV_BIT])
        else $error("empty read not flagged invalid");

    a_pop_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rd_result && fifo_out_valid && !res_valid_i) |=> fifo_count == $past(fifo_count) - 5'h01)
        else $error("result read did not pop one word");

    a_count_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fifo_count <= LW'(adcr_pkg::FIFO_DEPTH))
        else $error("fifo count above depth");

    // ==========================================================
    // Result word, FIFO, register and restart checks
    a_status_fields: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fmt == adcr_pkg::FMT_STATUS |-> packed_word[adcr_pkg::RES_CLIP_BIT] == res_clip_i
        && packed_word[adcr_pkg::RES_INV_BIT] == res_invalid_i
        && packed_word[adcr_pkg::RES_CHAN_MSB:adcr_pkg::RES_CHAN_LSB] == res_chan_i)
        else $error("status word fields misplaced");

    a_data_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fmt == adcr_pkg::FMT_DATA |-> packed_word[31:adcr_pkg::PROC_W] == '0
        && packed_word[adcr_pkg::PROC_W-1:0] == res_proc_i)
        else $error("data only word malformed");

    a_full_refuses: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fifo_count == LW'(adcr_pkg::FIFO_DEPTH) |-> !res_ready_o)
        else $error("fifo ready while full");

    a_empty_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rd_result && !fifo_out_valid && !res_valid_i) |=> fifo_count == '0)
        else $error("empty read changed fifo count");

    a_level_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (clr_level && !set_level) |=> !level_flag)
        else $error("level flag not cleared");

    a_polarity_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_polarity |=> polarity == $past(hwdata_i))
        else $error("format register write lost");

    a_restart_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rs_state == RS_IDLE && seq_done_i && continuous_i)
        |=> rs_state == RS_DELAY && delay_cnt == $past(restart_cnt))
        else $error("restart delay not loaded");

    a_start_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        seq_start_o |=> !seq_start_o)
        else $error("restart pulse longer than one cycle");

endmodule // adcr_top

// ===== test/adcr_core_model.sv
// Converter core stand-in: offers results on valid/ready and runs the sample clock.
// Assumes offer() is called just after a rising edge of clk_i.
`timescale 1ns/1ns
module adcr_core_model (
    // Clock
    input wire logic clk_i,
    // Result stream
    input wire logic res_ready_i,
    output logic res_valid_o,
    output logic [4:0] res_chan_o,
    output logic [11:0] res_proc_o,
    output logic [17:0] res_raw_o,
    output logic res_clip_o,
    output logic res_invalid_o,
    // Sample clock
    output logic sample_clk_o
);
    // ==========================================================
    // Sample clock, free running, 80 ns period
    initial begin
        {res_valid_o, res_chan_o, res_proc_o, res_raw_o, res_clip_o, res_invalid_o} = '0;
        sample_clk_o = 1'b0;
        forever #40 sample_clk_o = ~sample_clk_o;
    end

    // ==========================================================
    // One result, held until taken or for at most 200 cycles; fields scrambled once released
    task automatic offer(input logic [4:0] c, input logic [11:0] p, input logic [17:0] w,
                         input logic cl, input logic iv, input int gap, output logic ok);
        int k;
        repeat (gap) @(posedge clk_i);
        res_valid_o <= 1'b1;
        {res_chan_o, res_proc_o, res_raw_o, res_clip_o, res_invalid_o} <= {c, p, w, cl, iv};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (!res_ready_i && k < 200);
        ok = res_ready_i;
        res_valid_o <= 1'b0;
        {res_chan_o, res_proc_o, res_raw_o, res_clip_o, res_invalid_o} <= ~{c, p, w, cl, iv};
    endtask
endmodule // adcr_core_model

// ===== test/adcr_top_tb.sv
// Self-checking bench for the result path: registers, formats, FIFO, watermark, restart.
// Assumes a 125 MHz clock and the core model driving results and the sample clock.
`timescale 1ns/1ns
module adcr_top_tb;
    logic clk_i, rst_n_i, hsel_i, hwrite_i, continuous_i, seq_done_i, ok;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, v, r;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic hreadyout_o, hresp_o, seq_start_o, res_valid_i, res_ready_o, res_clip_i;
    logic res_invalid_i, dma_req_o, level_event_o, sample_clk_i;
    logic [15:0] chan_single_o;
    logic [4:0] res_chan_i;
    logic [11:0] res_proc_i;
    logic [17:0] res_raw_i;
    logic [31:0] exp_q [16];
    int seed, n_fail, tests_run, k, e;

    adcr_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .sample_clk_i(sample_clk_i), .continuous_i(continuous_i),
        .seq_done_i(seq_done_i), .seq_start_o(seq_start_o), .chan_single_o(chan_single_o),
        .res_valid_i(res_valid_i), .res_ready_o(res_ready_o), .res_chan_i(res_chan_i),
        .res_proc_i(res_proc_i), .res_raw_i(res_raw_i), .res_clip_i(res_clip_i),
        .res_invalid_i(res_invalid_i), .dma_req_o(dma_req_o), .level_event_o(level_event_o));
    adcr_core_model u_core (.clk_i(clk_i), .res_ready_i(res_ready_o), .res_valid_o(res_valid_i),
        .res_chan_o(res_chan_i), .res_proc_o(res_proc_i), .res_raw_o(res_raw_i),
        .res_clip_o(res_clip_i), .res_invalid_o(res_invalid_i), .sample_clk_o(sample_clk_i));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ==========================================================
    // Checking and closing
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic results();
        $display("Counts: %0d checks, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic give_up(input string msg);
        n_fail++;
        $display("CHECK FAILED at %0t: timeout %s", $time, msg);
        results();
    endtask

    // ==========================================================
    // AHB-Lite master, single word transfers
    task automatic wait_ready();
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (!hreadyout_o && k < 50);
        if (hreadyout_o !== 1'b1) give_up("bus");
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= {24'h0, a};
        hwrite_i <= wr;
        wait_ready();
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        wait_ready();
        rd = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    // ==========================================================
    // Expected values
    function automatic logic [31:0] pack(input logic [1:0] f, input logic [4:0] c,
        input logic [11:0] p, input logic [17:0] w, input logic cl, input logic iv);
        if (f == 2'h1) return {20'h0, p};
        if (f == 2'h2) return {14'h0, w};
        return {cl, 6'h0, iv, 3'h0, c, 4'h0, p};
    endfunction
    function automatic logic [31:0] stat(input int n);
        return {14'h0, n == 16, n == 0, 3'h0, 5'(n), 8'h0};
    endfunction
    task automatic status(input int n);
        ahb(1'b0, adcr_pkg::OFF_EVENT, 32'h0, r);
        check(r & 32'h0003_1F00, stat(n), "fifo level");
    endtask
    task automatic push(input logic [1:0] f, output logic [31:0] x);
        logic [31:0] a;
        logic [31:0] b;
        a = $random(seed);
        b = $random(seed);
        u_core.offer(a[4:0], a[19:8], b[17:0], a[31], a[30], 1 + int'(b[31:30]), ok);
        check({31'h0, ok}, 32'h1, "push taken");
        x = pack(f, a[4:0], a[19:8], b[17:0], a[31], a[30]);
    endtask
    task automatic restart(input int n);
        logic prev;
        wr(adcr_pkg::OFF_RESTART, n);
        continuous_i <= 1'b1;
        for (k = 0; k < 40 && sample_clk_i; k++) @(posedge clk_i);
        for (k = 0; k < 40 && !sample_clk_i; k++) @(posedge clk_i);
        repeat (5) @(posedge clk_i);
        seq_done_i <= 1'b1;
        @(posedge clk_i);
        seq_done_i <= 1'b0;
        e = 0;
        prev = sample_clk_i;
        for (k = 0; k < 1000 && !seq_start_o; k++) begin
            @(posedge clk_i);
            if (sample_clk_i && !prev) e++;
            prev = sample_clk_i;
        end
        if (seq_start_o !== 1'b1) give_up("restart");
        check(e, n, "restart delay");
        @(posedge clk_i);
        check({31'h0, seq_start_o}, 32'h0, "start pulse");
        continuous_i <= 1'b0;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        seed = 94;
        {n_fail, tests_run} = '0;
        {rst_n_i, hsel_i, hwrite_i, continuous_i, seq_done_i, htrans_i} = '0;
        {haddr_i, hwdata_i} = '0;
        hsize_i = 3'h2;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        ahb(1'b0, adcr_pkg::OFF_RESTART, 32'h0, r);
        check(r, 32'h0, "restart reset");
        ahb(1'b0, adcr_pkg::OFF_POLARITY, 32'h0, r);
        check(r, adcr_pkg::RST_POLARITY, "format reset");
        check({16'h0, chan_single_o}, {16'h0, adcr_pkg::RST_POLARITY[15:0]}, "modes");
        ahb(1'b0, adcr_pkg::OFF_FIFOCTL, 32'h0, r);
        check(r, 32'h0, "fifo ctl reset");
        ahb(1'b0, adcr_pkg::OFF_RESULT, 32'h0, r);
        check(r, adcr_pkg::RST_RESULT, "empty read");
        ahb(1'b0, 8'h10, 32'h0, r);
        check(r, 32'h0, "unmapped read");
        check({31'h0, hresp_o}, 32'h0, "okay response");
        status(0);
        $display("done: reset values");
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(adcr_pkg::OFF_POLARITY, v);
            ahb(1'b0, adcr_pkg::OFF_POLARITY, 32'h0, r);
            check(r, v, "format readback");
            check({16'h0, chan_single_o}, {16'h0, v[15:0]}, "modes");
            wr(adcr_pkg::OFF_RESTART, v);
            ahb(1'b0, adcr_pkg::OFF_RESTART, 32'h0, r);
            check(r, {16'h0, v[15:0]}, "restart readback");
        end
        wr(adcr_pkg::OFF_POLARITY, adcr_pkg::RST_POLARITY);
        $display("done: channel modes");
        for (int f = 0; f < 4; f++) begin
            wr(adcr_pkg::OFF_FIFOCTL, 32'(f) << 2);
            ahb(1'b0, adcr_pkg::OFF_FIFOCTL, 32'h0, r);
            check(r, 32'(f) << 2, "format field");
            push(2'(f), v);
            ahb(1'b0, adcr_pkg::OFF_RESULT, 32'h0, r);
            check(r, v, "packed word");
        end
        $display("done: word formats");
        wr(adcr_pkg::OFF_FIFOCTL, 32'h0000_0000);
        for (int i = 0; i < 16; i++) push(2'h0, exp_q[i]);
        @(posedge clk_i);
        check({31'h0, res_ready_o}, 32'h0, "full refuses");
        status(16);
        for (int i = 0; i < 16; i++) begin
            ahb(1'b0, adcr_pkg::OFF_RESULT, 32'h0, r);
            check(r, exp_q[i], "drain order");
            status(15 - i);
        end
        ahb(1'b0, adcr_pkg::OFF_RESULT, 32'h0, r);
        check(r, adcr_pkg::RST_RESULT, "read when empty");
        status(0);
        $display("done: fill and drain");
        wr(adcr_pkg::OFF_FIFOCTL, 32'h0000_0304);
        wr(adcr_pkg::OFF_EVENT, 32'h1);
        for (int i = 0; i < 4; i++) begin
            repeat (2) @(posedge clk_i);
            check({30'h0, level_event_o, dma_req_o}, 32'h0, "below watermark");
            push(2'h1, v);
        end
        repeat (2) @(posedge clk_i);
        check({30'h0, level_event_o, dma_req_o}, 32'h2, "dma gated");
        wr(adcr_pkg::OFF_FIFOCTL, 32'h0000_0305);
        repeat (2) @(posedge clk_i);
        check({30'h0, level_event_o, dma_req_o}, 32'h3, "dma request");
        ahb(1'b0, adcr_pkg::OFF_RESULT, 32'h0, r);
        repeat (2) @(posedge clk_i);
        check({30'h0, level_event_o, dma_req_o}, 32'h2, "request drops");
        wr(adcr_pkg::OFF_EVENT, 32'h1);
        repeat (2) @(posedge clk_i);
        check({31'h0, level_event_o}, 32'h0, "flag cleared");
        $display("done: watermark");
        push(2'h1, v);
        status(4);
        wr(adcr_pkg::OFF_FIFOCTL, 32'h0000_0300);
        status(4);
        wr(adcr_pkg::OFF_FIFOCTL, 32'h0000_0306);
        ahb(1'b0, adcr_pkg::OFF_FIFOCTL, 32'h0, r);
        check(r, 32'h0000_0304, "flush reads 0");
        status(0);
        $display("done: flush");
        restart(0);
        restart(3);
        restart(1 + ($random(seed) & 3));
        $display("done: restart delay");
        results();
    end
endmodule // adcr_top_tb
